/* hdl/triple_comparator_event_control.v */
// Top of the triple comparator event control: APB register file and three comparator channels.
// Assumes idle_mode and the PWM outputs come from logic on pclk; comparator outputs are asynchronous.
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "comparator_regs.vh"
module triple_comparator_event_control (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        idle_mode,
	input  wire [2:0]  raw_result,
	input  wire        pwm_low_one,
	input  wire        pwm_high_one,
	input  wire        pwm_low_two,
	input  wire        pwm_high_two,
	input  wire        pwm_low_three,
	input  wire        pwm_high_three,
	output reg  [2:0]  comparator_on,
	output reg  [2:0]  plus_select,
	output reg  [5:0]  minus_select,
	output reg  [2:0]  result_pin,
	output reg  [2:0]  result_pin_oe,
	output reg  [2:0]  event_irq,
	output reg  [2:0]  mask_a,
	output reg  [2:0]  mask_b,
	output reg  [2:0]  mask_c
);

	// ****************************************************************
	// Address decode
	// ****************************************************************
	function addr_is;
		input [11:0] addr;
		input [11:0] off;
		begin
			addr_is = (addr[11:2] == off[11:2]);
		end
	endfunction

	wire        setup_phase;
	wire        access_done;
	wire        wr_now;
	wire [5:0]  pwm_bus;
	wire [47:0] setup_w;
	wire [47:0] source_w;
	wire [2:0]  result_w;
	wire [2:0]  hit_w;
	wire [2:0]  active_w;
	wire [2:0]  sel_setup_w;
	wire [2:0]  sel_source_w;
	wire [2:0]  mask_a_w;
	wire [2:0]  mask_b_w;
	wire [2:0]  mask_c_w;
	wire        sel_summary;
	wire        mapped;
	wire [15:0] summary_w;
	reg  [15:0] summary_q;
	reg  [15:0] summary_d;
	reg  [15:0] read_word;

	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable & pready;
	assign wr_now      = access_done & pwrite;
	assign pwm_bus     = {pwm_high_three, pwm_low_three, pwm_high_two, pwm_low_two, pwm_high_one, pwm_low_one};
	assign sel_summary = addr_is(paddr, `CMP_SUMMARY_OFF);
	assign mapped      = sel_summary | (|sel_setup_w) | (|sel_source_w);

	// ****************************************************************
	// Shared summary register
	// ****************************************************************
	// Only the idle halt bit is stored; the event and result bits are live mirrors
	always @* begin
		summary_d = summary_q;
		if (wr_now && sel_summary) begin
			summary_d = pwdata[15:0] & `CMP_SUMMARY_WMASK;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			summary_q <= `CMP_RESET_VALUE;
		end else begin
			summary_q <= summary_d;
		end
	end

	assign summary_w = {summary_q[15:11],
		setup_w[32+`CMP_EVENT_BIT], setup_w[16+`CMP_EVENT_BIT], setup_w[`CMP_EVENT_BIT],
		5'h00,
		setup_w[32+`CMP_RESULT_BIT], setup_w[16+`CMP_RESULT_BIT], setup_w[`CMP_RESULT_BIT]};

	// ****************************************************************
	// Per-comparator registers and channels
	// ****************************************************************
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : ch
			reg  [15:0] setup_q;
			reg  [15:0] setup_d;
			reg  [15:0] source_q;
			reg  [15:0] source_d;
			wire [11:0] setup_off;
			wire [11:0] source_off;
			// Offsets are worked out at full integer width, then cut to the bus width
			localparam [31:0] setup_sum  = `CMP_SETUP_BASE + `CMP_CH_STRIDE * i;
			localparam [31:0] source_sum = `CMP_SOURCE_BASE + `CMP_CH_STRIDE * i;

			assign setup_off       = setup_sum[11:0];
			assign source_off      = source_sum[11:0];
			assign sel_setup_w[i]  = addr_is(paddr, setup_off);
			assign sel_source_w[i] = addr_is(paddr, source_off);

			// A halted comparator behaves as disabled until Idle ends
			assign active_w[i] = setup_q[`CMP_ON_BIT]
				& ~(summary_q[`CMP_IDLE_HALT_BIT] & idle_mode);

			compare_channel u_chan (
				.pclk     (pclk),
				.presetn  (presetn),
				.raw_in   (raw_result[i]),
				.active   (active_w[i]),
				.invert   (setup_q[`CMP_INV_BIT]),
				.edge_sel (setup_q[`CMP_EDGE_HI:`CMP_EDGE_LO]),
				.blocked  (setup_q[`CMP_EVENT_BIT]),
				.result_q (result_w[i]),
				.edge_hit (hit_w[i])
			);

			always @* begin
				setup_d = setup_q;
				if (wr_now && sel_setup_w[i]) begin
					// Writing zero to the event bit re-arms the comparator
					setup_d = (pwdata[15:0] & `CMP_SETUP_WMASK)
						| (setup_q & ~`CMP_SETUP_WMASK);
				end
				setup_d[`CMP_RESULT_BIT] = result_w[i];
				// Set wins over a clearing write in the same cycle
				if (hit_w[i]) begin
					setup_d[`CMP_EVENT_BIT] = 1'b1;
				end
			end

			always @* begin
				source_d = source_q;
				if (wr_now && sel_source_w[i]) begin
					source_d = pwdata[15:0] & `CMP_SOURCE_WMASK;
				end
			end

			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					setup_q  <= `CMP_RESET_VALUE;
					source_q <= `CMP_RESET_VALUE;
				end else begin
					setup_q  <= setup_d;
					source_q <= source_d;
				end
			end

			mask_source_mux u_mask_c (
				.pwm_in   (pwm_bus),
				.code     (source_q[`CMP_SRC_C_LSB+3:`CMP_SRC_C_LSB]),
				.mask_out (mask_c_w[i])
			);

			mask_source_mux u_mask_b (
				.pwm_in   (pwm_bus),
				.code     (source_q[`CMP_SRC_B_LSB+3:`CMP_SRC_B_LSB]),
				.mask_out (mask_b_w[i])
			);

			mask_source_mux u_mask_a (
				.pwm_in   (pwm_bus),
				.code     (source_q[`CMP_SRC_A_LSB+3:`CMP_SRC_A_LSB]),
				.mask_out (mask_a_w[i])
			);

			assign setup_w[16*i +: 16]  = setup_q;
			assign source_w[16*i +: 16] = source_q;
		end
	endgenerate

	// ****************************************************************
	// Outputs toward the analog side and the PWM blanking logic
	// ****************************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comparator_on <= 3'h0;
			plus_select   <= 3'h0;
			minus_select  <= 6'h00;
			result_pin    <= 3'h0;
			result_pin_oe <= 3'h0;
			event_irq     <= 3'h0;
			mask_a        <= 3'h0;
			mask_b        <= 3'h0;
			mask_c        <= 3'h0;
		end else begin
			comparator_on <= active_w;
			plus_select   <= {setup_w[32+`CMP_PLUS_BIT], setup_w[16+`CMP_PLUS_BIT],
				setup_w[`CMP_PLUS_BIT]};
			minus_select  <= {setup_w[33:32], setup_w[17:16], setup_w[1:0]};
			result_pin_oe <= {setup_w[32+`CMP_PIN_BIT], setup_w[16+`CMP_PIN_BIT],
				setup_w[`CMP_PIN_BIT]};
			result_pin    <= result_w & {setup_w[32+`CMP_PIN_BIT], setup_w[16+`CMP_PIN_BIT],
				setup_w[`CMP_PIN_BIT]};
			event_irq     <= hit_w;
			mask_a        <= mask_a_w;
			mask_b        <= mask_b_w;
			mask_c        <= mask_c_w;
		end
	end

	// ****************************************************************
	// APB slave
	// ****************************************************************
	// Read data are captured in the setup cycle; an event landing in the access cycle shows on the next read
	always @* begin
		read_word = 16'h0000;
		if (sel_summary) begin
			read_word = summary_w;
		end else if (sel_setup_w[0]) begin
			read_word = setup_w[15:0];
		end else if (sel_setup_w[1]) begin
			read_word = setup_w[31:16];
		end else if (sel_setup_w[2]) begin
			read_word = setup_w[47:32];
		end else if (sel_source_w[0]) begin
			read_word = source_w[15:0];
		end else if (sel_source_w[1]) begin
			read_word = source_w[31:16];
		end else if (sel_source_w[2]) begin
			read_word = source_w[47:32];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup_phase;
			if (setup_phase) begin
				prdata  <= pwrite ? 32'h00000000 : {16'h0000, read_word};
				pslverr <= ~mapped;
			end else if (access_done) begin
				prdata  <= 32'h00000000;
				pslverr <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* hdl/comparator_regs.vh */
// Register offsets, field positions and reset values of the triple comparator event control block.
// Assumes a 32-bit APB slave port; every register is one aligned word, data in the low 16 bits.
`ifndef COMPARATOR_REGS_VH
`define COMPARATOR_REGS_VH

// ****************************************************************
// Offsets
// ****************************************************************
`define CMP_SUMMARY_OFF   12'h000
`define CMP_SETUP_BASE    12'h004
`define CMP_SOURCE_BASE   12'h008
`define CMP_CH_STRIDE     12'h008

// ****************************************************************
// Fields
// ****************************************************************
`define CMP_IDLE_HALT_BIT 15
`define CMP_EVT_LSB       8
`define CMP_RES_LSB       0
`define CMP_ON_BIT        15
`define CMP_PIN_BIT       14
`define CMP_INV_BIT       13
`define CMP_EVENT_BIT     9
`define CMP_RESULT_BIT    8
`define CMP_EDGE_HI       7
`define CMP_EDGE_LO       6
`define CMP_PLUS_BIT      4
`define CMP_MINUS_HI      1
`define CMP_MINUS_LO      0
`define CMP_SRC_C_LSB     8
`define CMP_SRC_B_LSB     4
`define CMP_SRC_A_LSB     0

// ****************************************************************
// Write masks and reset values
// ****************************************************************
`define CMP_SUMMARY_WMASK 16'h8000
`define CMP_SETUP_WMASK   16'he2d3
`define CMP_SOURCE_WMASK  16'h0fff
`define CMP_RESET_VALUE   16'h0000

// ****************************************************************
// Edge select codes
// ****************************************************************
`define CMP_EDGE_NONE     2'b00
`define CMP_EDGE_RISE     2'b01
`define CMP_EDGE_FALL     2'b10
`define CMP_EDGE_ANY      2'b11

`endif

/* hdl/compare_channel.v */
// One comparator's digital side: result synchroniser, polarity and edge detection.
// Assumes raw_in comes straight from an analog front end, asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
`include "comparator_regs.vh"
module compare_channel (
	input  wire       pclk,
	input  wire       presetn,
	input  wire       raw_in,
	input  wire       active,
	input  wire       invert,
	input  wire [1:0] edge_sel,
	input  wire       blocked,
	output reg        result_q,
	output reg        edge_hit
);
	reg  sync1_q;
	reg  sync2_q;
	wire result_d;

	// ****************************************************************
	// Synchroniser and adjusted result
	// ****************************************************************
	// Held at zero while inactive, so enabling may itself give a rising edge
	assign result_d = active & (sync2_q ^ invert);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q  <= 1'b0;
			sync2_q  <= 1'b0;
			result_q <= 1'b0;
		end else begin
			sync1_q  <= raw_in;
			sync2_q  <= sync1_q;
			result_q <= result_d;
		end
	end

	// ****************************************************************
	// Edge detection
	// ****************************************************************
	always @* begin
		edge_hit = 1'b0;
		if (active && !blocked) begin
			case (edge_sel)
				`CMP_EDGE_ANY:  edge_hit = result_d ^ result_q;
				`CMP_EDGE_FALL: edge_hit = result_q & ~result_d;
				`CMP_EDGE_RISE: edge_hit = result_d & ~result_q;
				default:        edge_hit = 1'b0;
			endcase
		end
	end
endmodule
`default_nettype wire

/* hdl/mask_source_mux.v */
// Picks one of six PWM outputs for a blanking mask input.
// Assumes the PWM outputs are generated on pclk.
`timescale 1ns/1ps
`default_nettype none
module mask_source_mux (
	input  wire [5:0] pwm_in,
	input  wire [3:0] code,
	output reg        mask_out
);
	// pwm_in order: low one, high one, low two, high two, low three, high three
	always @* begin
		case (code)
			4'h0:    mask_out = pwm_in[0];
			4'h1:    mask_out = pwm_in[1];
			4'h2:    mask_out = pwm_in[2];
			4'h3:    mask_out = pwm_in[3];
			4'h4:    mask_out = pwm_in[4];
			4'h5:    mask_out = pwm_in[5];
			default: mask_out = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

/* verif/comparator_far_side.sv */
// Far-side model: analog comparator outputs and the six PWM lines.
// Assumes the bench sets the wanted levels; raw results settle off the clock grid.
`timescale 1ns/1ps
`default_nettype none
module comparator_far_side (
	input  wire logic       pclk,
	input  wire logic [2:0] want_raw,
	input  wire logic [5:0] want_pwm,
	output var  logic [2:0] raw_result,
	output var  logic [5:0] pwm
);
	initial raw_result = 3'h0;
	initial pwm = 6'h00;
	// Analog outputs move asynchronously to pclk, so the synchroniser is exercised
	always @(want_raw) raw_result <= #7 want_raw;
	always @(posedge pclk) pwm <= want_pwm;
endmodule
`default_nettype wire

/* verif/triple_comparator_event_control_assertions.sv */
// Port checker for the triple comparator event control.
// Assumes one clock pclk and asynchronous active-low presetn.
`timescale 1ns/1ps
`default_nettype none
module event_ctl_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [5:0]  minus_select,
	input wire logic [2:0]  result_pin,
	input wire logic [2:0]  result_pin_oe,
	input wire logic [2:0]  event_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ready_after_setup; psel && !penable |=> pready; endproperty
	a_ready_after_setup: assert property (p_ready_after_setup)
		else $error("ready missing after setup");
	property p_ready_once; pready |=> !pready; endproperty
	a_ready_once: assert property (p_ready_once)
		else $error("ready longer than one cycle");
	property p_err_with_ready; pslverr |-> pready; endproperty
	a_err_with_ready: assert property (p_err_with_ready)
		else $error("error without ready");
	property p_upper_zero; prdata[31:16] == 16'h0000; endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("upper read bits set");
	property p_idle_data; !pready |-> prdata == 32'h0; endproperty
	a_idle_data: assert property (p_idle_data)
		else $error("read data outside access");
	property p_pin_oe; (result_pin & ~result_pin_oe) == 3'h0; endproperty
	a_pin_oe: assert property (p_pin_oe)
		else $error("pin driven while internal only");
	property p_irq_gap0;
		event_irq[0] |=> !event_irq[0] ##1 (!event_irq[0] || $past(psel && penable && pwrite));
	endproperty
	a_irq_gap0: assert property (p_irq_gap0)
		else $error("event repeated while latched");
	property p_irq_gap2;
		event_irq[2] |=> !event_irq[2] ##1 (!event_irq[2] || $past(psel && penable && pwrite));
	endproperty
	a_irq_gap2: assert property (p_irq_gap2)
		else $error("event pulse too long");
	property p_minus_by_write;
		$changed(minus_select) |-> $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2);
	endproperty
	a_minus_by_write: assert property (p_minus_by_write)
		else $error("minus select moved without write");
endmodule
bind triple_comparator_event_control event_ctl_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.minus_select(minus_select), .result_pin(result_pin), .result_pin_oe(result_pin_oe), .event_irq(event_irq));
`default_nettype wire

/* verif/triple_comparator_event_control_bench.sv */
// Self-checking bench for the triple comparator event control.
// Assumes the far-side model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module triple_comparator_event_control_bench;
	logic        pclk = 0;
	logic        presetn = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic        idle_mode = 0;
	logic        pready, pslverr, er;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [2:0]  want_raw = 0, raw_result, comparator_on, plus_select, result_pin, result_pin_oe, event_irq;
	logic [2:0]  mask_a, mask_b, mask_c;
	logic [5:0]  want_pwm = 0, pwm, minus_select;
	logic [11:0] ra [8] = '{12'h00, 12'h04, 12'h08, 12'h0c, 12'h10, 12'h14, 12'h18, 12'h1c};
	// Source rows carry defined codes only; the top nibble probes the unimplemented bits
	logic [31:0] rw [8] = '{32'hffff, 32'h5ed3, 32'hf345, 32'h5ed3, 32'hf025, 32'h5ed3, 32'h1234, 32'hffff};
	logic [31:0] rx [8] = '{32'h8000, 32'h42d3, 32'h0345, 32'h42d3, 32'h0025, 32'h42d3, 32'h0234, 32'h0};
	int          fail_count = 0, cmp_count = 0, irq_n = 0, irq0, i;

	always #10 pclk = ~pclk;
	always @(posedge pclk) if (event_irq[0] === 1'b1) irq_n++;

	comparator_far_side far (.pclk(pclk), .want_raw(want_raw), .want_pwm(want_pwm), .raw_result(raw_result),
		.pwm(pwm));
	triple_comparator_event_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.idle_mode(idle_mode), .raw_result(raw_result), .pwm_low_one(pwm[0]), .pwm_high_one(pwm[1]),
		.pwm_low_two(pwm[2]), .pwm_high_two(pwm[3]), .pwm_low_three(pwm[4]), .pwm_high_three(pwm[5]),
		.comparator_on(comparator_on), .plus_select(plus_select), .minus_select(minus_select),
		.result_pin(result_pin), .result_pin_oe(result_pin_oe), .event_irq(event_irq), .mask_a(mask_a),
		.mask_b(mask_b), .mask_c(mask_c));

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		// No cycle count assumed; a dead slave is ended by the watchdog
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task conclude;
		if (fail_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1;
		for (i = 0; i < 7; i++) begin
			apb(0, 12'h004 * i, 0);
			chk(rd, 0);
		end
		for (i = 0; i < 8; i++) begin
			apb(1, ra[i], rw[i]);
			apb(0, ra[i], 0);
			chk(rd, rx[i]);
			chk(er, i == 7);
		end
		chk(result_pin_oe, 3'h7);
		chk(plus_select, 3'h7);
		chk(minus_select, 6'h3f);
		chk(comparator_on, 3'h0);
		apb(0, 12'h000, 0);
		chk(rd, 32'h8700);
		for (i = 0; i < 4; i++) apb(1, 12'h008 * i + ((i == 0) ? 0 : 12'h004 - 12'h008 + 12'h008), 0);
		for (i = 0; i < 3; i++) apb(1, 12'h004 + 12'h008 * i, 0);
		for (i = 0; i < 6; i++) begin
			apb(1, 12'h008, {20'h0, i[3:0], i[3:0], i[3:0]});
			want_pwm <= 6'h01 << i;
			repeat (3) @(posedge pclk);
			chk({mask_c[0], mask_b[0], mask_a[0]}, 3'h7);
			chk({mask_c[1], mask_b[1], mask_a[1]}, {i == 0, i == 2, i == 5});
			chk({mask_c[2], mask_b[2], mask_a[2]}, {i == 2, i == 3, i == 4});
			want_pwm <= ~(6'h01 << i);
			repeat (3) @(posedge pclk);
			chk({mask_c[0], mask_b[0], mask_a[0]}, 3'h0);
		end
		apb(1, 12'h004, 32'he000);
		repeat (6) @(posedge pclk);
		apb(0, 12'h004, 0);
		chk(rd, 32'he100);
		chk(result_pin[0], 1);
		apb(1, 12'h000, 32'h8000);
		idle_mode <= 1;
		repeat (3) @(posedge pclk);
		chk(comparator_on[0], 0);
		apb(0, 12'h000, 0);
		chk(rd, 32'h8000);
		idle_mode <= 0;
		repeat (6) @(posedge pclk);
		apb(0, 12'h000, 0);
		chk(rd, 32'h8001);
		apb(1, 12'h000, 0);
		idle_mode <= 1;
		repeat (3) @(posedge pclk);
		chk(comparator_on[0], 1);
		idle_mode <= 0;
		apb(1, 12'h004, 0);
		for (i = 0; i < 4; i++) begin
			apb(1, 12'h004, 32'h8000 | (i << 6));
			irq0 = irq_n;
			want_raw <= 3'h1;
			repeat (6) @(posedge pclk);
			apb(0, 12'h000, 0);
			chk(rd, {23'h0, i[0], 8'h01});
			chk(irq_n - irq0, i[0]);
			apb(1, 12'h004, 32'h8000 | (i << 6));
			want_raw <= 3'h0;
			repeat (6) @(posedge pclk);
			apb(0, 12'h000, 0);
			chk(rd, {23'h0, i[1], 8'h00});
		end
		irq0 = irq_n;
		want_raw <= 3'h1;
		repeat (6) @(posedge pclk);
		apb(0, 12'h000, 0);
		chk(rd, 32'h0101);
		chk(irq_n - irq0, 0);
		apb(1, 12'h014, 32'h80c0);
		want_raw <= 3'h5;
		repeat (6) @(posedge pclk);
		apb(0, 12'h000, 0);
		chk(rd, 32'h0505);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		apb(0, 12'h004, 0);
		chk(rd, 0);
		conclude;
	end
	initial begin
		#1000000;
		fail_count++;
		conclude;
	end
endmodule
`default_nettype wire
